// ### hw/rotate_datapath.v
// rotate-left-no-carry / rotate-right-through-carry execution datapath
//
// Contract
// - left rotate shifts the byte one place toward bit 7.
// - left rotate moves old bit 7 into bit 0, carry untouched.
// - right rotate shifts one place toward bit 0 through carry.
// - right rotate loads carry from old bit 0, old carry into bit 7.
// - destination bit zero writes working register, source byte kept.
// - destination bit one writes result back to source byte.
// - access bit zero resolves address in the access bank.
// - access bit one uses the bank select register for the bank.
// - access zero, extended set, address up to 5Fh: indexed offset.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "rotate_defines.vh"

module rotate_datapath (
    input wire i_clk,
    input wire i_resetn,
    input wire i_start,
    input wire i_op,
    input wire i_dest,
    input wire i_access,
    input wire [7:0] i_file_addr,
    input wire i_extended_en,
    input wire [11:0] i_index_base,
    input wire [3:0] i_bsr_wdata,
    input wire i_bsr_we,
    input wire [7:0] i_mem_rdata,
    output reg [11:0] o_mem_addr,
    output reg o_mem_re,
    output reg o_mem_we,
    output reg [7:0] o_mem_wdata,
    output reg [7:0] o_wreg,
    output reg o_carry,
    output reg [3:0] o_bank_select,
    output reg [1:0] o_phase,
    output wire o_busy,
    output reg o_done
);

    ////////////////////////////////////////////////////////////////////////
    // address resolution
    function [11:0] resolve_addr;
        input acc;
        input ext;
        input [7:0] f;
        input [3:0] bank_select_register;
        input [11:0] base;
        begin
            if (acc == `BANK_SELECTED) begin
                resolve_addr = {bank_select_register, f};
            end else if (ext && (f <= `INDEXED_MAX)) begin
                resolve_addr = base + {4'h0, f};
            end else if (f < `ACCESS_SPLIT) begin
                resolve_addr = {4'h0, f};
            end else begin
                resolve_addr = {`ACCESS_HIGH_BANK, f};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // byte rotations
    // old bit 7 wraps to bit 0
    function [7:0] rotate_left_byte;
        input [7:0] b;
        begin
            rotate_left_byte = {b[6:0], b[7]};
        end
    endfunction

    function [7:0] rotate_right_byte;
        input [7:0] b;
        input c;
        begin
            rotate_right_byte = {c, b[7:1]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // phase codes
    localparam [1:0] PH_DECODE = `PHASE_DECODE;
    localparam [1:0] PH_READ = `PHASE_READ;
    localparam [1:0] PH_PROCESS = `PHASE_PROCESS;
    localparam [1:0] PH_WRITE = `PHASE_WRITE;

    ////////////////////////////////////////////////////////////////////////
    // state
    reg [1:0] phase_reg;
    reg [1:0] phase_next;
    reg active_reg;
    reg op_reg;
    reg dest_reg;
    reg [11:0] addr_reg;
    reg [7:0] operand_reg;
    reg [7:0] result_reg;
    reg carry_new_reg;
    wire start_take;
    wire in_read;
    wire in_process;
    wire in_write;
    wire write_file;
    wire write_wreg;
    wire [11:0] eff_addr;

    assign o_busy = active_reg;
    // new instruction only accepted while idle
    assign start_take = i_start && !active_reg;
    assign in_read = active_reg && (phase_reg == PH_READ);
    assign in_process = active_reg && (phase_reg == PH_PROCESS);
    assign in_write = active_reg && (phase_reg == PH_WRITE);
    // result back to the source byte
    assign write_file = in_write && (dest_reg == `DEST_FILE);
    assign write_wreg = in_write && (dest_reg == `DEST_WORKING);

    assign eff_addr = resolve_addr(i_access, i_extended_en, i_file_addr,
        o_bank_select, i_index_base);

    ////////////////////////////////////////////////////////////////////////
    // phase sequencing
    // decode, read, process, write
    always @* begin
        case (phase_reg)
            PH_DECODE: phase_next = PH_READ;
            PH_READ: phase_next = PH_PROCESS;
            PH_PROCESS: phase_next = PH_WRITE;
            PH_WRITE: phase_next = PH_DECODE;
            default: phase_next = PH_DECODE;
        endcase
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_reg <= PH_DECODE;
        end else if (active_reg || start_take) begin
            phase_reg <= phase_next;
        end
    end

    // phase mirror for observers
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_phase <= PH_DECODE;
        end else if (active_reg || start_take) begin
            o_phase <= phase_next;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            active_reg <= 1'b0;
        end else if (start_take) begin
            active_reg <= 1'b1;
        end else if (in_write) begin
            active_reg <= 1'b0;
        end
    end

    // end of instruction pulse
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_done <= 1'b0;
        end else begin
            o_done <= in_write;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode: operand capture
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            op_reg <= 1'b0;
            dest_reg <= 1'b0;
        end else if (start_take) begin
            op_reg <= i_op;
            dest_reg <= i_dest;
        end
    end

    // resolved address held for write back
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_reg <= 12'h000;
        end else if (start_take) begin
            addr_reg <= eff_addr;
        end
    end

    // bank select only reloads between instructions
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bank_select <= `BSR_RESET;
        end else if (i_bsr_we && !active_reg) begin
            o_bank_select <= i_bsr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory port
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_addr <= 12'h000;
        end else if (start_take) begin
            o_mem_addr <= eff_addr;
        end else if (write_file) begin
            o_mem_addr <= addr_reg;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_re <= 1'b0;
        end else begin
            o_mem_re <= start_take;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_we <= 1'b0;
        end else begin
            o_mem_we <= write_file;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_wdata <= 8'h00;
        end else if (write_file) begin
            o_mem_wdata <= result_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // datapath
    // read operand
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            operand_reg <= 8'h00;
        end else if (in_read) begin
            operand_reg <= i_mem_rdata;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            result_reg <= 8'h00;
            carry_new_reg <= 1'b0;
        end else if (in_process) begin
            if (op_reg == `OP_ROT_LEFT_NO_CARRY) begin
                result_reg <= rotate_left_byte(operand_reg);
                carry_new_reg <= o_carry;
            end else begin
                result_reg <= rotate_right_byte(operand_reg, o_carry);
                carry_new_reg <= operand_reg[0];
            end
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_carry <= `CARRY_RESET;
        end else if (in_write) begin
            o_carry <= carry_new_reg;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wreg <= `WREG_RESET;
        end else if (write_wreg) begin
            o_wreg <= result_reg;
        end
    end

endmodule // rotate_datapath

// ### hw/rotate_defines.vh
// constants for the rotate instruction datapath
`ifndef ROTATE_DEFINES_VH
`define ROTATE_DEFINES_VH
`define OP_ROT_LEFT_NO_CARRY 1'b0
`define OP_ROT_RIGHT_CARRY 1'b1
`define DEST_WORKING 1'b0
`define DEST_FILE 1'b1
`define BANK_ACCESS 1'b0
`define BANK_SELECTED 1'b1
`define ACCESS_SPLIT 8'h80
`define INDEXED_MAX 8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define PHASE_DECODE 2'h0
`define PHASE_READ 2'h1
`define PHASE_PROCESS 2'h2
`define PHASE_WRITE 2'h3
`define WREG_RESET 8'h00
`define CARRY_RESET 1'b0
`define BSR_RESET 4'h0
`endif

// ### verif/rotate_datapath_props.sv
// assertions for the rotate instruction datapath
`timescale 1ns/10ps
module rotate_datapath_props (
    input wire i_clk, i_resetn, i_start, i_op, i_dest, i_access, i_extended_en,
    input wire [7:0] i_file_addr, i_mem_rdata, o_mem_wdata, o_wreg,
    input wire [11:0] i_index_base, o_mem_addr,
    input wire [3:0] o_bank_select,
    input wire [1:0] o_phase,
    input wire o_mem_re, o_mem_we, o_carry, o_busy, o_done
);
reg re_q, op_q, dst_q, c_q;
reg [7:0] rd_q;
wire take = i_start && !o_busy;
wire [7:0] res = dst_q ? o_mem_wdata : o_wreg;
// operands at start, byte one edge after the read sample edge
always @(posedge i_clk) begin
    re_q <= o_mem_re;
    if (re_q) rd_q <= i_mem_rdata;
    if (take) begin
        op_q <= i_op;
        dst_q <= i_dest;
        c_q <= o_carry;
    end
end
default clocking @(posedge i_clk); endclocking
default disable iff (!i_resetn);
sequence s_walk;
    o_mem_re && o_phase == 2'h1 ##1 o_phase == 2'h2 ##1 o_phase == 2'h3
    ##1 o_done && o_phase == 2'h0;
endsequence
////////////////////////////////////////////////////////////////
a_phase_walk: assert property (take |=> s_walk)
    else $error("phase walk broken");
a_left_rotate: assert property (o_done && !op_q |->
    res == {rd_q[6:0], rd_q[7]} && o_carry == c_q) else $error("left rotate wrong");
a_right_rotate: assert property (o_done && op_q |->
    res == {c_q, rd_q[7:1]} && o_carry == rd_q[0]) else $error("right rotate wrong");
a_write_select: assert property (o_done |-> o_mem_we == dst_q)
    else $error("destination write wrong");
a_write_when_done: assert property (o_mem_we |-> o_done)
    else $error("stray memory write");
a_bank_addr: assert property (take && i_access |=>
    o_mem_addr == {$past(o_bank_select), $past(i_file_addr)}) else $error("banked addr");
a_access_low: assert property (take && !i_access
    && !(i_extended_en && i_file_addr <= 8'h5F)
    |=> o_mem_addr == {{4{$past(i_file_addr[7])}}, $past(i_file_addr)})
    else $error("access bank addr");
a_indexed_addr: assert property (take && !i_access
    && i_extended_en && i_file_addr <= 8'h5F
    |=> o_mem_addr == $past(i_index_base) + $past(i_file_addr))
    else $error("indexed addr");
a_busy_span: assert property (take |=> o_busy [*3] ##1 !o_busy)
    else $error("busy span wrong");
endmodule // rotate_datapath_props

// ### verif/rotate_datapath_tb_top.sv
// random and corner tests for the rotate datapath
`timescale 1ns/10ps
module rotate_datapath_tb_top;
reg i_clk = 0, i_resetn = 0, i_start = 0, i_op = 0, i_dest = 0, i_access = 0;
reg i_extended_en = 0, i_bsr_we = 0, c = 0;
reg [7:0] i_file_addr = 8'h00, i_mem_rdata = 8'h00, w = 8'h00, r;
reg [11:0] i_index_base = 12'h000, a;
reg [3:0] i_bsr_wdata = 4'h0;
wire [11:0] o_mem_addr;
wire [7:0] o_mem_wdata, o_wreg;
wire [3:0] o_bank_select;
wire [1:0] o_phase;
wire o_mem_re, o_mem_we, o_carry, o_busy, o_done;
integer n_mismatch = 0, checks = 0, k;
always #5 i_clk = ~i_clk;
rotate_datapath u_rotate_datapath (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(i_start),
    .i_op(i_op),
    .i_dest(i_dest),
    .i_access(i_access),
    .i_file_addr(i_file_addr),
    .i_extended_en(i_extended_en),
    .i_index_base(i_index_base),
    .i_bsr_wdata(i_bsr_wdata),
    .i_bsr_we(i_bsr_we),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_addr(o_mem_addr),
    .o_mem_re(o_mem_re),
    .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata),
    .o_wreg(o_wreg),
    .o_carry(o_carry),
    .o_bank_select(o_bank_select),
    .o_phase(o_phase),
    .o_busy(o_busy),
    .o_done(o_done)
);
task ck(input [11:0] e, s, input [8*5:1] n);
    checks = checks + 1;
    if (e !== s) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0s exp %h got %h", n, e, s);
    end
endtask
task summarize;
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
task go(input op, dst, acc, ext, input [7:0] f, d, input [3:0] b);
    @(posedge i_clk) i_bsr_we <= 1;
    i_bsr_wdata <= b;
    @(posedge i_clk) i_bsr_we <= 0;
    {i_start, i_op, i_dest, i_access, i_extended_en} <= {1'b1, op, dst, acc, ext};
    i_file_addr <= f;
    i_mem_rdata <= d;
    i_index_base <= $urandom;
    @(posedge i_clk) i_start <= 0;
    i_bsr_we <= 1;
    i_bsr_wdata <= ~b;
    @(posedge i_clk) i_bsr_we <= 0;
    repeat (2) @(posedge i_clk);
    #1;
    a = acc ? {b, f} : (ext && f <= 8'h5F) ? i_index_base + f : {{4{f[7]}}, f};
    r = op ? {c, d[7:1]} : {d[6:0], d[7]};
    if (op) c = d[0];
    if (!dst) w = r;
    ck(1, o_done, "done");
    ck(a, o_mem_addr, "addr");
    ck(dst, o_mem_we, "we");
    ck(w, o_wreg, "wreg");
    if (dst) ck(r, o_mem_wdata, "wdata");
    ck(c, o_carry, "carry");
    ck(b, o_bank_select, "bsr");
endtask
initial begin
    k = $urandom(43);
    repeat (2) @(posedge i_clk);
    i_resetn <= 1;
    go(0, 0, 0, 1, 8'h5F, 8'hAB, 4'h3);
    go(1, 0, 0, 1, 8'h60, 8'h01, 4'h0);
    go(1, 1, 0, 0, 8'hFF, 8'h00, 4'hF);
    go(0, 1, 1, 1, 8'h10, 8'h80, 4'h5);
    for (k = 0; k < 200; k = k + 1)
        go($urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
    summarize;
end
initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    summarize;
end
endmodule // rotate_datapath_tb_top
bind rotate_datapath rotate_datapath_props u_rotate_datapath_props (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(i_start),
    .i_op(i_op),
    .i_dest(i_dest),
    .i_access(i_access),
    .i_extended_en(i_extended_en),
    .i_file_addr(i_file_addr),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_wdata(o_mem_wdata),
    .o_wreg(o_wreg),
    .i_index_base(i_index_base),
    .o_mem_addr(o_mem_addr),
    .o_bank_select(o_bank_select),
    .o_phase(o_phase),
    .o_mem_re(o_mem_re),
    .o_mem_we(o_mem_we),
    .o_carry(o_carry),
    .o_busy(o_busy),
    .o_done(o_done)
);
